// file: verilog/tx_status_pkg.sv
package tx_status_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] done_counts_off  = 16'h8418;
  localparam logic [15:0] term_status_off  = 16'h841c;
  localparam logic [15:0] fifo_data_off    = 16'h8440;
  localparam logic [15:0] rsvd_lo_off      = 16'h8420;
  localparam logic [15:0] rsvd_hi_off      = 16'h843c;
  localparam logic [15:0] block_lo_off     = 16'h8400;
  localparam logic [15:0] block_hi_off     = 16'h847c;
  localparam logic [31:0] reg_reset        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int bytes_lsb     = 16;
  localparam int normal_bit    = 24;
  localparam int ro_wr_bit     = 23;
  localparam int rsv_wr_bit    = 22;
  localparam int rsv_rd_bit    = 21;
  localparam int fifo_bit      = 20;
  localparam int sys_bit       = 19;
  localparam int try_bit       = 18;
  localparam int tgt_bit       = 17;
  localparam int init_bit      = 16;
  localparam int flag_lsb      = 16;
  localparam int flag_msb      = 24;
  localparam logic [7:0] try_unlimited = 8'h00;

  // Interrupt enable bundle from the enables register
  typedef struct packed {
    logic normal_end_irq_en;
    logic fifo_fault_irq_en;
    logic sys_fault_irq_en;
    logic try_limit_irq_en;
    logic tgt_abort_irq_en;
    logic init_abort_irq_en;
  } irq_en_s;

  // Transfer events from the master controller
  typedef struct packed {
    logic packet_start;
    logic beat_ok;
    logic packet_done;
    logic retry;
    logic tgt_abort;
    logic init_abort;
    logic illegal_state;
  } xfer_ev_s;

  // Slave bus request
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bus_req_s;

endpackage

// file: verilog/tx_status_counters.sv
module tx_status_counters #(
  parameter int fifo_depth = 32,
  parameter int aw         = 5
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // Slave register bus
  input  wire tx_status_pkg::bus_req_s     bus_req,
  output logic                             bus_ack,
  output logic                             bus_err,
  output logic [31:0]                      bus_rdata,
  // Controls from the enables and size registers
  input  wire logic                        controller_reset_bit,
  input  wire logic                        master_enable,
  input  wire logic                        continuous_mode,
  input  wire logic                        bus_fault_enable,
  input  wire tx_status_pkg::irq_en_s      irq_en,
  input  wire logic [15:0]                 packet_size,
  input  wire logic [7:0]                  max_retries,
  input  wire logic [31:0]                 start_addr,
  // Master controller events and FIFO error input
  input  wire tx_status_pkg::xfer_ev_s     xfer_ev,
  input  wire logic                        fifo_error,
  // Master controller drain port
  input  wire logic                        drain_req,
  output logic                             drain_valid,
  output logic [31:0]                      drain_data,
  // Bus address, FIFO state and interrupt
  output logic [31:0]                      bus_addr,
  output logic                             fifo_full,
  output logic                             fifo_empty,
  output logic                             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]   bytes_done_ff;
  logic [15:0]   packets_done_ff;
  logic [8:0]    flags_ff;
  logic [7:0]    retry_cnt_ff;
  logic          me_dropped_ff;
  logic          in_packet_ff;
  logic [31:0]   mem [fifo_depth];
  logic [aw:0]   wptr_ff;
  logic [aw:0]   rptr_ff;
  logic [aw:0]   level;
  logic          is_counts;
  logic          is_status;
  logic          is_data;
  logic          is_rsvd;
  logic          in_block;
  logic          wr_ro;
  logic          wr_rsv;
  logic          rd_rsv;
  logic          push;
  logic          pop_bus;
  logic          pop_drain;
  logic          pop;
  logic [8:0]    set_vec;
  logic [8:0]    clr_vec;
  logic          try_over;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign is_counts = bus_req.addr == tx_status_pkg::done_counts_off;
  assign is_status = bus_req.addr == tx_status_pkg::term_status_off;
  assign is_data   = bus_req.addr == tx_status_pkg::fifo_data_off;
  assign is_rsvd   = bus_req.addr >= tx_status_pkg::rsvd_lo_off && bus_req.addr <= tx_status_pkg::rsvd_hi_off;
  assign in_block  = bus_req.addr >= tx_status_pkg::block_lo_off && bus_req.addr <= tx_status_pkg::block_hi_off;
  assign wr_ro     = bus_req.sel && bus_req.wr && is_counts;
  assign wr_rsv    = bus_req.sel && bus_req.wr && is_rsvd;
  assign rd_rsv    = bus_req.sel && !bus_req.wr && is_rsvd;

  // FIFO port strobes, partial byte enables are not filtered
  assign level     = wptr_ff - rptr_ff;
  assign push      = bus_req.sel && bus_req.wr && is_data && (level != (aw+1)'(fifo_depth));
  assign pop_bus   = bus_req.sel && !bus_req.wr && is_data && (level != '0);
  assign pop_drain = drain_req && !pop_bus && (level != '0);
  assign pop       = pop_bus || pop_drain;

  // ----------------------------------------------------------------
  // Bus response, one cycle after request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_ack   <= 1'b0;
      bus_err   <= 1'b0;
      bus_rdata <= tx_status_pkg::reg_reset;
    end else begin
      bus_ack   <= bus_req.sel && in_block;
      bus_err   <= bus_fault_enable && (wr_ro || wr_rsv || rd_rsv);
      bus_rdata <= tx_status_pkg::reg_reset;
      if (bus_req.sel && !bus_req.wr) begin
        if (is_counts)
          bus_rdata <= {bytes_done_ff, packets_done_ff};
        else if (is_status)
          bus_rdata <= {7'h00, flags_ff, 16'h0000};
        else if (is_data)
          bus_rdata <= mem[rptr_ff[aw-1:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bytes_done_ff <= 16'h0000;
    end else if (controller_reset_bit || xfer_ev.packet_start) begin
      bytes_done_ff <= 16'h0000;
    end else if (xfer_ev.beat_ok && bytes_done_ff != packet_size) begin
      bytes_done_ff <= bytes_done_ff + 16'h0004;
    end
  end

  // ----------------------------------------------------------------
  // Packet counter and enable-drop tracking
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_packet_ff  <= 1'b0;
      me_dropped_ff <= 1'b0;
    end else begin
      if (xfer_ev.packet_start)
        in_packet_ff <= 1'b1;
      else if (xfer_ev.packet_done || xfer_ev.tgt_abort || xfer_ev.init_abort || controller_reset_bit)
        in_packet_ff <= 1'b0;
      if (master_enable || controller_reset_bit || xfer_ev.packet_done)
        me_dropped_ff <= 1'b0;
      else if (in_packet_ff)
        me_dropped_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      packets_done_ff <= 16'h0000;
    end else if (controller_reset_bit) begin
      packets_done_ff <= 16'h0000;
    end else if (xfer_ev.packet_done && me_dropped_ff && !master_enable) begin
      packets_done_ff <= 16'h0000;
    end else if (xfer_ev.packet_done && continuous_mode) begin
      packets_done_ff <= packets_done_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Bus address: restart loads start only outside continuous mode
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_addr <= tx_status_pkg::reg_reset;
    end else if (controller_reset_bit || (xfer_ev.packet_start && !continuous_mode)) begin
      bus_addr <= start_addr;
    end else if (xfer_ev.beat_ok) begin
      bus_addr <= bus_addr + 32'h0000_0004;
    end
  end

  // ----------------------------------------------------------------
  // Retry counter, cleared per packet
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      retry_cnt_ff <= 8'h00;
    end else if (xfer_ev.packet_start) begin
      retry_cnt_ff <= 8'h00;
    end else if (xfer_ev.retry && retry_cnt_ff != 8'hff) begin
      retry_cnt_ff <= retry_cnt_ff + 8'h01;
    end
  end
  // Fires on every retry once the count has reached the limit, so a later retry sets the flag again after a clear
  assign try_over = max_retries != tx_status_pkg::try_unlimited && xfer_ev.retry && retry_cnt_ff >= max_retries;

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  assign set_vec = {xfer_ev.packet_done, wr_ro, wr_rsv, rd_rsv, fifo_error,
                    xfer_ev.illegal_state, try_over, xfer_ev.tgt_abort, xfer_ev.init_abort};
  assign clr_vec = (bus_req.sel && bus_req.wr && is_status) ?
                   bus_req.wdata[tx_status_pkg::flag_msb:tx_status_pkg::flag_lsb] : 9'h000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= 9'h000;
    end else begin
      flags_ff <= (flags_ff & ~clr_vec) | set_vec;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (flags_ff[8] & irq_en.normal_end_irq_en) | (flags_ff[4] & irq_en.fifo_fault_irq_en)
           | (flags_ff[3] & irq_en.sys_fault_irq_en) | (flags_ff[2] & irq_en.try_limit_irq_en)
           | (flags_ff[1] & irq_en.tgt_abort_irq_en) | (flags_ff[0] & irq_en.init_abort_irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (push)
      mem[wptr_ff[aw-1:0]] <= bus_req.wdata;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_ff     <= '0;
      rptr_ff     <= '0;
      drain_valid <= 1'b0;
      drain_data  <= tx_status_pkg::reg_reset;
      fifo_full   <= 1'b0;
      fifo_empty  <= 1'b1;
    end else begin
      if (push)
        wptr_ff <= wptr_ff + 1'b1;
      if (pop)
        rptr_ff <= rptr_ff + 1'b1;
      drain_valid <= pop_drain;
      if (pop_drain)
        drain_data <= mem[rptr_ff[aw-1:0]];
      fifo_full  <= (wptr_ff + (aw+1)'(push) - (aw+1)'(pop) - rptr_ff) == (aw+1)'(fifo_depth);
      fifo_empty <= (wptr_ff + (aw+1)'(push) - (aw+1)'(pop) - rptr_ff) == '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    xfer_ev.packet_done |=> flags_ff[8]) else $error("normal flag not set");
  ro_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ro |=> flags_ff[7] && ($stable(bytes_done_ff) || $past(xfer_ev.beat_ok) || $past(xfer_ev.packet_start)
              || $past(controller_reset_bit))) else $error("ro flag");
  wr_rsv_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_rsv |=> flags_ff[6]) else $error("reserved write flag");
  rd_rsv_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_rsv |=> flags_ff[5]) else $error("reserved read flag");
  w1c_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clr_vec == 9'h000) && flags_ff[0] |=> flags_ff[0]) else $error("flag lost");
  pkt_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    controller_reset_bit |=> packets_done_ff == 16'h0000) else $error("packet count not cleared");
  pkt_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    !continuous_mode && !controller_reset_bit |=> packets_done_ff <= $past(packets_done_ff))
    else $error("packet count moved");
  restart_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    xfer_ev.packet_start |=> bytes_done_ff == 16'h0000) else $error("bytes not zeroed");
  err_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    bus_err |-> $past(bus_fault_enable)) else $error("error without enable");
  irq_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    flags_ff[8] && irq_en.normal_end_irq_en |=> irq) else $error("irq missing");
  try_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    try_over |=> flags_ff[2]) else $error("retry flag not set");

  push_c:  cover property (@(posedge sys_clk) disable iff (rst) push ##[1:4] pop_drain);
  cont_c:  cover property (@(posedge sys_clk) disable iff (rst) continuous_mode && xfer_ev.packet_done);
  try_c:   cover property (@(posedge sys_clk) disable iff (rst) try_over);
  fault_c: cover property (@(posedge sys_clk) disable iff (rst) bus_fault_enable && (wr_ro || wr_rsv || rd_rsv));

endmodule

// file: testbench/far_master.sv
// ------------------------------------------------
// Master controller model: events and drain port
// ------------------------------------------------
module far_master (
  // Clock
  input  wire logic               sys_clk,
  // Transfer events
  output tx_status_pkg::xfer_ev_s xfer_ev,
  // Dedicated drain port
  output logic                    drain_req,
  input  wire logic               drain_valid,
  input  wire logic [31:0]        drain_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at time zero
  initial begin
    xfer_ev = '0;
    drain_req = 1'b0;
  end

  // One-cycle event pulse, then idle
  task automatic pulse(input logic [6:0] m);
    @(negedge sys_clk);
    xfer_ev = tx_status_pkg::xfer_ev_s'(m);
    @(negedge sys_clk);
    xfer_ev = '0;
  endtask

  // Pop one word through the drain port
  task automatic drain(output logic [31:0] d, output logic ok);
    @(negedge sys_clk);
    drain_req = 1'b1;
    @(negedge sys_clk);
    ok = drain_valid;
    d = drain_data;
    drain_req = 1'b0;
  endtask
endmodule

// file: testbench/tx_status_counters_bench.sv
module tx_status_counters_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic                     sys_clk, rst, bus_ack, bus_err, irq, er, ok;
  logic                     controller_reset_bit, master_enable, continuous_mode;
  logic                     bus_fault_enable, fifo_error, drain_req, drain_valid, fifo_full, fifo_empty;
  logic [31:0]              bus_rdata, start_addr, drain_data, bus_addr, rd, d;
  logic [15:0]              packet_size;
  logic [7:0]               max_retries;
  tx_status_pkg::bus_req_s  bus_req;
  tx_status_pkg::irq_en_s   irq_en;
  tx_status_pkg::xfer_ev_s  xfer_ev;
  int                       n_mismatch, comparisons, cycles;
  localparam logic [15:0]   cnt = tx_status_pkg::done_counts_off;
  localparam logic [15:0]   sts = tx_status_pkg::term_status_off;
  localparam logic [15:0]   fdp = tx_status_pkg::fifo_data_off;

  tx_status_counters DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_ack(bus_ack), .bus_err(bus_err),
    .bus_rdata(bus_rdata), .controller_reset_bit(controller_reset_bit), .master_enable(master_enable),
    .continuous_mode(continuous_mode), .bus_fault_enable(bus_fault_enable), .irq_en(irq_en),
    .packet_size(packet_size), .max_retries(max_retries), .start_addr(start_addr), .xfer_ev(xfer_ev),
    .fifo_error(fifo_error), .drain_req(drain_req), .drain_valid(drain_valid), .drain_data(drain_data),
    .bus_addr(bus_addr), .fifo_full(fifo_full), .fifo_empty(fifo_empty), .irq(irq));
  far_master fm (.sys_clk(sys_clk), .xfer_ev(xfer_ev), .drain_req(drain_req), .drain_valid(drain_valid),
    .drain_data(drain_data));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One register access, answer taken with ack
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(negedge sys_clk);
    bus_req = '{sel: 1'b1, wr: w, addr: a, be: 4'hf, wdata: wd};
    @(negedge sys_clk);
    chk({31'h0, bus_ack}, 32'h1, "ack");
    rd = bus_rdata;
    er = bus_err;
    bus_req.sel = 1'b0;
  endtask

  task automatic ctl_pulse();
    @(negedge sys_clk);
    controller_reset_bit = 1'b1;
    @(negedge sys_clk);
    controller_reset_bit = 1'b0;
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_count();
    packet_size = 16'd12;
    continuous_mode = 1'b1;
    irq_en = '{normal_end_irq_en: 1'b1, default: 1'b0};
    ctl_pulse();
    fm.pulse(7'h40);
    repeat (3) fm.pulse(7'h20);
    bus(0, cnt, 0); chk(rd, {16'd12, 16'd0}, "bytes");
    fm.pulse(7'h10);
    bus(0, cnt, 0); chk(rd, {16'd12, 16'd1}, "done");
    bus(0, sts, 0); chk(rd, 32'h0100_0000, "normal flag");
    chk({31'h0, irq}, 32'h1, "irq");
    fm.pulse(7'h40);
    bus(0, cnt, 0); chk(rd, {16'd0, 16'd1}, "restart");
    fm.pulse(7'h20);
    chk(bus_addr, 32'h0000_0110, "addr");
    bus(1, sts, 0); bus(0, sts, 0); chk(rd, 32'h0100_0000, "w0");
    bus(1, sts, 32'h0100_0000); bus(0, sts, 0); chk(rd, 0, "w1c");
    chk({31'h0, irq}, 32'h0, "irq clear");
  endtask

  task automatic t_packets();
    continuous_mode = 1'b0;
    fm.pulse(7'h40); fm.pulse(7'h10);
    bus(0, cnt, 0); chk(rd, 32'h0000_0001, "no count");
    continuous_mode = 1'b1;
    fm.pulse(7'h40); fm.pulse(7'h20);
    master_enable = 1'b0;
    fm.pulse(7'h10);
    bus(0, cnt, 0); chk(rd, {16'd4, 16'd0}, "enable drop");
    chk(bus_addr, 32'h0000_0104, "addr kept");
    master_enable = 1'b1;
    fm.pulse(7'h40); fm.pulse(7'h10);
    bus(0, cnt, 0); chk(rd, 32'h0000_0001, "count");
    start_addr = 32'h0000_0200;
    ctl_pulse();
    chk(bus_addr, 32'h0000_0200, "start reload");
    bus(0, cnt, 0); chk(rd, 0, "ctl reset");
    bus(1, sts, 32'h01ff_0000);
  endtask

  task automatic t_faults();
    logic [15:0] a [3] = '{cnt, tx_status_pkg::rsvd_lo_off, tx_status_pkg::rsvd_hi_off};
    for (int i = 0; i < 6; i++) begin
      bus_fault_enable = i[0];
      bus(i < 4, a[i/2], 32'hffff_ffff);
      chk({31'h0, er}, {31'h0, i[0]}, "bus err");
      bus(0, sts, 0); chk(rd, 32'h0080_0000 >> (i/2), "fault flag");
      bus(1, sts, rd);
    end
    bus(0, cnt, 0); chk(rd, 0, "no corruption");
  endtask

  task automatic t_events();
    logic [6:0] m [3] = '{7'h01, 7'h04, 7'h02};
    irq_en = '1;
    fm.pulse(7'h40); fm.pulse(7'h20);
    for (int i = 0; i < 3; i++) begin
      fm.pulse(m[i]);
      bus(0, sts, 0); chk(rd, 32'h0008_0000 >> (i * 2 - (i == 2)), "event");
      chk({31'h0, irq}, 32'h1, "event irq");
      bus(1, sts, rd);
    end
    bus(0, cnt, 0); chk(rd, {16'd4, 16'd0}, "bytes kept");
    fifo_error = 1'b1;
    bus(1, sts, 32'h0010_0000); bus(0, sts, 0); chk(rd, 32'h0010_0000, "fifo flag");
    fifo_error = 1'b0;
    bus(1, sts, 32'h0010_0000); bus(0, sts, 0); chk(rd, 0, "fifo clear");
    irq_en = '0;
    fm.pulse(7'h04);
    bus(0, sts, 0); chk({31'h0, irq}, 32'h0, "masked");
    bus(1, sts, rd);
  endtask

  task automatic t_retry();
    max_retries = 8'h02;
    fm.pulse(7'h40);
    repeat (2) fm.pulse(7'h08);
    bus(0, sts, 0); chk(rd, 0, "at limit");
    fm.pulse(7'h08);
    bus(0, sts, 0); chk(rd, 32'h0004_0000, "over limit");
    bus(1, sts, rd);
    fm.pulse(7'h40);
    repeat (2) fm.pulse(7'h08);
    bus(0, sts, 0); chk(rd, 0, "per packet");
  endtask

  task automatic t_fifo();
    for (int i = 0; i < 33; i++) bus(1, fdp, 32'ha000 + i);
    chk({31'h0, fifo_full}, 32'h1, "full");
    fm.drain(d, ok); chk(d, 32'ha000, "drain");
    bus(0, fdp, 0); chk(rd, 32'ha001, "pop");
    for (int i = 2; i < 32; i++) begin
      fm.drain(d, ok); chk(d, 32'ha000 + i, "drain order");
    end
    chk({31'h0, fifo_empty}, 32'h1, "empty");
    fm.drain(d, ok); chk({31'h0, ok}, 32'h0, "empty drain");
  endtask

  // ------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    {rst, controller_reset_bit, master_enable, continuous_mode, bus_fault_enable, fifo_error} = 6'b101000;
    bus_req = '0; irq_en = '0; packet_size = 0; max_retries = 0; start_addr = 32'h0000_0100;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    chk({29'h0, fifo_empty, fifo_full, irq}, 32'h4, "reset outputs");
    bus(0, cnt, 0); chk(rd, 0, "counts reset");
    bus(0, sts, 0); chk(rd, 0, "status reset");
    t_count(); t_packets(); t_faults(); t_events(); t_retry(); t_fifo();
    give_verdict();
  end
endmodule
